// ### common/packet_port_defines.svh
// Register map, field positions, reset values and codes for the packet port mux
//
// Contract
// - Offer three fast MII ports or two redundant gigabit GMII/TBI ports.
// - TBI mode puts a 1000BASE-X coding sublayer between MAC and pins (the code only syncs on commas; code groups pass through unchanged).
// - TBI mode leaves auto-negotiation disabled; only software may run it.
// - Gigabit modes receive on one gigabit port only; the other is standby.
// - Accept only the listed port combinations of gigabit and fast ports.
// - Ports 2 and 3 never receive at once; both may transmit (the code never enables ports 2 and 3 together).
// - A received PAUSE frame causes no action; transmission never stalls.
// - All packet outputs are high impedance while system reset is low.
// - Frame formats and interface behaviour follow the Ethernet standard.
// - Pin use depends on mode: 4-bit MII, 8-bit GMII, 10-bit TBI code groups.
// - Link, traffic and speed indicators are active low.
// - TBI receive samples on rising edges of two opposite-phase byte clocks.
`ifndef PACKET_PORT_DEFINES_SVH
`define PACKET_PORT_DEFINES_SVH

// APB byte addresses
`define PP_ADDR_PORT_MODE   12'h000
`define PP_ADDR_RX_CTRL     12'h004
`define PP_ADDR_STATUS      12'h008

// Port mode field: two bits per port, port n at bit 2n
`define PP_MODE_W           2
`define PP_MODE_RESET       8'h00

// Receive control fields
`define PP_RX_PORT_LSB      0
`define PP_RX_PORT_MSB      1
`define PP_RX_ANEG_BIT      2
`define PP_RX_CTRL_RESET    3'h0

// Status fields
`define PP_ST_REJECT_BIT    0
`define PP_ST_SYNC_BIT      1
`define PP_ST_RXSEEN_BIT    2

// Code-group lane: valid and error bits in MII/GMII
`define PP_CODE_VALID_BIT   8
`define PP_CODE_ERROR_BIT   9

// Comma patterns of both running disparities
`define PP_COMMA_POS        7'h1f
`define PP_COMMA_NEG        7'h60
`define PP_SYNC_COMMAS      2'h3

`endif

// ### common/packet_port_pkg.sv
// Types shared by the packet port mux and its receive lane
package packet_port_pkg;

   typedef enum logic [1:0] {
      MODE_OFF  = 2'b00,
      MODE_FAST = 2'b01,
      MODE_GMII = 2'b10,
      MODE_TBI  = 2'b11
   } port_mode_type;

   typedef enum logic [1:0] {
      SYNC_LOST     = 2'b00,
      SYNC_ACQUIRE  = 2'b01,
      SYNC_LOCKED   = 2'b10
   } sync_state_type;

endpackage

// ### dv/phy_model.sv
// Stand-in PHY/SerDes: receive clocks and per-port receive pins
module phy_model (
   output logic            o_rx_clock_a,
   output logic            o_rx_clock_b,
   output logic [3:0][9:0] o_rx_code
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////
   // free-running receive clocks
   // Second clock is the inverse: 180 degrees apart, as in ten-bit mode
   initial begin
      o_rx_clock_a = 1'b0;
      o_rx_code    = '0;
      #7;
      forever #32 o_rx_clock_a = ~o_rx_clock_a;
   end
   assign o_rx_clock_b = ~o_rx_clock_a;

   ////////////////////////////////////////////////////////////////////////
   // code groups change just after the rising clock edge
   // Afterwards the lane drops valid and shows inverted data, never stale bits
   task automatic send(input logic [1:0] port, input logic [9:0] code, input int n);
      // Port select written just before needs two link edges to reach the lane
      repeat (3) @(posedge o_rx_clock_a);
      repeat (n) begin
         @(posedge o_rx_clock_a);
         o_rx_code[port] <= code;
      end
      @(posedge o_rx_clock_a);
      o_rx_code[port] <= {2'b00, ~code[7:0]};
   endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the packet port mode mux
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic            clock;
   logic            rstn    = 1'b0;
   logic            psel    = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite  = 1'b0;
   logic [11:0]     paddr   = 12'h000;
   logic [31:0]     pwdata  = 32'h0;
   logic [3:0][9:0] tx_data = '0;
   logic            rx_clock_a, rx_clock_b, pready, pslverr, rx_valid, err, g;
   logic [31:0]     prdata, rd;
   logic [3:0][9:0] rx_code, txd;
   logic [3:0]      txd_oe, gtx, gtx_oe, link_n, traffic_n, speed_n, ind_oe;
   logic [9:0]      rx_data, last_data;
   logic [1:0]      rx_port, last_port;
   logic [7:0]      expm    = 8'h00;
   int              n_fail  = 0;
   int              checked = 0;
   int              n_rx    = 0;
   // Rows: {legal, port mode word}
   logic [8:0]      rows [14] = '{9'h10a, 9'h006, 9'h10f, 9'h00e, 9'h112, 9'h052, 9'h143,
                                  9'h002, 9'h010, 9'h100, 9'h105, 9'h055, 9'h115, 9'h145};
   logic [7:0]      pause [10] = '{8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01, 8'h88, 8'h08, 8'h00, 8'h01};

   packet_port_mode_mux dut (
      .i_clock(clock), .i_rstn(rstn), .i_rx_byte_clock_a(rx_clock_a), .i_rx_byte_clock_b(rx_clock_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_rx_code(rx_code), .i_tx_data(tx_data),
      .o_txd(txd), .o_txd_oe(txd_oe), .o_gig_transmit_clock(gtx), .o_gig_transmit_clock_oe(gtx_oe),
      .o_port_link_indicator_n(link_n), .o_port_traffic_indicator_n(traffic_n),
      .o_port_speed_indicator_n(speed_n), .o_indicator_oe(ind_oe), .o_rx_data(rx_data),
      .o_rx_valid(rx_valid), .o_rx_port(rx_port));

   phy_model phy (.o_rx_clock_a(rx_clock_a), .o_rx_clock_b(rx_clock_b), .o_rx_code(rx_code));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (rx_valid === 1'b1) begin
         n_rx++;
         last_data = rx_data;
         last_port = rx_port;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Held until pready is sampled high; the wait is bounded
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int t;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (pready !== 1'b1 && t < 50);
      chk(t < 50, 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   // Lanes need link edges in reset as well, so the hold outlasts five cycles
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      repeat (4) @(posedge rx_clock_a);
      @(posedge clock);
      chk({txd_oe, gtx_oe, ind_oe, link_n}, {12'h000, 4'hf});
      chk(txd, 40'h0);
      rstn <= 1'b1;
      @(posedge clock);
   endtask

   task automatic rx_wait(input int n, input logic [1:0] port, input logic [7:0] d, input logic [7:0] m);
      int t;
      t = 0;
      while (n_rx < n && t < 400) begin
         @(posedge clock);
         t++;
      end
      // Extra span catches words from a port that must stay silent
      repeat (40) @(posedge clock);
      chk({n_rx[7:0], last_port, last_data[7:0] & m}, {n[7:0], port, d});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   initial begin
      do_reset();
      foreach (rows[i]) begin
         apb(1'b1, 12'h000, {24'h0, rows[i][7:0]});
         expm = rows[i][8] ? rows[i][7:0] : expm;
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, expm);
         apb(1'b0, 12'h008, 32'h0);
         chk(rd[0], !rows[i][8]);
         apb(1'b1, 12'h008, 32'h1);
         for (int p = 0; p < 4; p++) begin
            chk(txd_oe[p], expm[2*p +: 2] != 2'b00);
            chk({gtx_oe[p], speed_n[p]}, {expm[2*p+1], !expm[2*p+1]});
         end
      end
      apb(1'b1, 12'h00c, 32'hff);
      chk(err, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b0, 12'h000, 32'h0);
      chk({err, rd}, {1'b0, 32'h45});
      apb(1'b1, 12'h004, 32'h3);
      n_rx = 0;
      fork
         phy.send(2'd3, 10'h10a, 1);
         phy.send(2'd2, 10'h105, 1);
      join
      rx_wait(1, 2'd3, 8'h0a, 8'h0f);
      apb(1'b1, 12'h000, 32'h0a);
      n_rx = 0;
      fork
         phy.send(2'd0, 10'h1a5, 1);
         phy.send(2'd1, 10'h13c, 1);
      join
      rx_wait(1, 2'd0, 8'ha5, 8'hff);
      apb(1'b1, 12'h004, 32'h2);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[1:0], 2'd0);
      tx_data[0] <= 10'h1c3;
      repeat (3) @(posedge clock);
      chk(txd[0], 10'h1c3);
      g = gtx[0];
      @(posedge clock);
      chk(gtx[0], !g);
      apb(1'b1, 12'h000, 32'h0f);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[1], 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[2], 1'b0);
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[2:0], 3'h4);
      phy.send(2'd0, 10'h0f8, 3);
      repeat (40) @(posedge clock);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[1], 1'b1);
      chk(link_n[1:0], 2'b10);
      apb(1'b1, 12'h000, 32'h05);
      tx_data[0] <= 10'h1f6;
      // Words still in flight from ten-bit mode must drain before counting
      repeat (4) @(posedge rx_clock_a);
      n_rx = 0;
      // Flow-control frame arrives while transmit runs; upper nibble is dropped on MII
      fork
         foreach (pause[k]) begin
            phy.send(2'd0, {6'h10, pause[k][3:0]}, 1);
            phy.send(2'd0, {6'h10, pause[k][7:4]}, 1);
         end
         repeat (300) begin
            @(posedge clock);
            chk({txd[0], traffic_n[0]}, {10'h106, 1'b0});
         end
      join
      rx_wait(20, 2'd0, 8'h00, 8'h0f);
      do_reset();
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      final_report();
   end
endmodule

// ### hdl/packet_port_mode_mux.sv
// Packet port mode mux: APB config, legal-combination check, pin mapping
//
// Implementation choices: the register offsets and the APB interface to the registers.
`include "packet_port_defines.svh"

module packet_port_mode_mux (
   input  wire logic                  i_clock,
   input  wire logic                  i_rstn,
   input  wire logic                  i_rx_byte_clock_a,
   input  wire logic                  i_rx_byte_clock_b,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [3:0][9:0]       i_rx_code,
   input  wire logic [3:0][9:0]       i_tx_data,
   output logic      [3:0][9:0]       o_txd,
   output logic      [3:0]            o_txd_oe,
   output logic      [3:0]            o_gig_transmit_clock,
   output logic      [3:0]            o_gig_transmit_clock_oe,
   output logic      [3:0]            o_port_link_indicator_n,
   output logic      [3:0]            o_port_traffic_indicator_n,
   output logic      [3:0]            o_port_speed_indicator_n,
   output logic      [3:0]            o_indicator_oe,
   output logic      [9:0]            o_rx_data,
   output logic                       o_rx_valid,
   output logic      [1:0]            o_rx_port
);
   import packet_port_pkg::*;

   typedef port_mode_type [3:0] mode_set_type;
   port_mode_type [3:0] mode_reg;
   logic [1:0]          rx_port_reg;
   logic                aneg_reg;
   logic                reject_reg;
   logic                rx_seen_reg;
   logic                wr_en;
   logic                rd_setup;
   logic                addr_ok;
   logic [31:0]         rd_next;
   port_mode_type [3:0] wr_mode;
   logic                wr_mode_ok;
   logic                wr_port_ok;
   logic                tbi_mode;
   logic [9:0]          word_a;
   logic [9:0]          word_b;
   logic                tog_a;
   logic                tog_b;
   logic                sync_a;
   logic [2:0]          tog_a_reg;
   logic [2:0]          tog_b_reg;
   logic [1:0]          sync_reg;
   logic                pend_b_reg;
   logic                take_a;
   logic                take_b;

   ////////////////////////////////////////////////////////////////////////
   // Legal combinations

   function automatic logic is_gig(input port_mode_type m);
      is_gig = (m == MODE_GMII) || (m == MODE_TBI);
   endfunction

   // all off, two or three fast, two gigabit, or one gigabit plus one fast port
   function automatic logic combo_ok(input port_mode_type [3:0] m);
      logic both_fast_hi;
      logic one_hi;
      both_fast_hi = (m[2] == MODE_FAST) && (m[3] == MODE_FAST);
      one_hi       = ((m[2] == MODE_FAST) ^ (m[3] == MODE_FAST));
      if (m == {MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF}) begin
         combo_ok = 1'b1;
      end else if (is_gig(m[0]) && m[1] == m[0]) begin
         combo_ok = (m[2] == MODE_OFF) && (m[3] == MODE_OFF);
      end else if (is_gig(m[0]) && m[1] == MODE_OFF) begin
         combo_ok = one_hi && !is_gig(m[2]) && !is_gig(m[3]);
      end else if (m[0] == MODE_FAST && m[1] == MODE_FAST) begin
         combo_ok = !both_fast_hi && !is_gig(m[2]) && !is_gig(m[3]);
      end else begin
         combo_ok = 1'b0;
      end
   endfunction

   assign wr_mode    = mode_set_type'(pwdata[7:0]);
   assign wr_mode_ok = combo_ok(wr_mode);
   // receive port must be configured, and port 0 or 1 when port 0 is gigabit
   // one receive port at a time keeps ports 2 and 3 exclusive
   assign wr_port_ok = (mode_reg[pwdata[1:0]] != MODE_OFF) &&
                       (!is_gig(mode_reg[0]) || !pwdata[1]);
   assign tbi_mode   = (mode_reg[rx_port_reg] == MODE_TBI);

   ////////////////////////////////////////////////////////////////////////
   // APB slave, no wait state; read data leaves a flop

   assign rd_setup = psel && !penable && !pready;
   assign wr_en    = psel && penable && pready && pwrite && addr_ok;
   assign addr_ok  = (paddr == `PP_ADDR_PORT_MODE) || (paddr == `PP_ADDR_RX_CTRL) ||
                     (paddr == `PP_ADDR_STATUS);

   always_comb begin
      rd_next = 32'h0000_0000;
      case (paddr)
         `PP_ADDR_PORT_MODE: rd_next[7:0] = mode_reg;
         `PP_ADDR_RX_CTRL:   rd_next[2:0] = {aneg_reg, rx_port_reg};
         `PP_ADDR_STATUS:    rd_next[2:0] = {rx_seen_reg, sync_reg[1], reject_reg};
         default:            rd_next      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_setup;
         pslverr <= rd_setup && !addr_ok;
         prdata  <= (rd_setup && !pwrite) ? rd_next : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         mode_reg <= mode_set_type'(`PP_MODE_RESET);
      end else if (wr_en && paddr == `PP_ADDR_PORT_MODE && wr_mode_ok) begin
         mode_reg <= wr_mode;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         {aneg_reg, rx_port_reg} <= `PP_RX_CTRL_RESET;
      end else if (wr_en && paddr == `PP_ADDR_PORT_MODE && wr_mode_ok) begin
         aneg_reg    <= 1'b0;
         rx_port_reg <= 2'h0;
      end else if (wr_en && paddr == `PP_ADDR_RX_CTRL && wr_port_ok) begin
         aneg_reg    <= pwdata[`PP_RX_ANEG_BIT];
         rx_port_reg <= pwdata[`PP_RX_PORT_MSB:`PP_RX_PORT_LSB];
      end
   end

   // sticky refusal flag, set beats clear
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         reject_reg <= 1'b0;
      end else if ((wr_en && paddr == `PP_ADDR_PORT_MODE && !wr_mode_ok) ||
                   (wr_en && paddr == `PP_ADDR_RX_CTRL && !wr_port_ok)) begin
         reject_reg <= 1'b1;
      end else if (wr_en && paddr == `PP_ADDR_STATUS && pwdata[`PP_ST_REJECT_BIT]) begin
         reject_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive lanes, one per byte clock

   // lane a runs on the PHY receive clock outside TBI
   rx_code_lane lane_a (
      .i_link_clock (i_rx_byte_clock_a),
      .i_rstn       (i_rstn),
      .i_rx_code    (i_rx_code),
      .i_rx_port    (rx_port_reg),
      .i_tbi_mode   (tbi_mode),
      .o_word       (word_a),
      .o_toggle     (tog_a),
      .o_sync       (sync_a)
   );

   rx_code_lane lane_b (
      .i_link_clock (i_rx_byte_clock_b),
      .i_rstn       (i_rstn),
      .i_rx_code    (i_rx_code),
      .i_rx_port    (rx_port_reg),
      .i_tbi_mode   (tbi_mode),
      .o_word       (word_b),
      .o_toggle     (tog_b),
      .o_sync       ()
   );

   // Toggles cross by two flops; words are stable a full link cycle after
   always_ff @(posedge i_clock) begin
      tog_a_reg <= {tog_a_reg[1:0], tog_a};
      tog_b_reg <= {tog_b_reg[1:0], tog_b};
      sync_reg  <= {sync_reg[0], sync_a};
   end

   assign take_a = tog_a_reg[2] ^ tog_a_reg[1];
   // Lane b is a second byte clock only in TBI; it waits one cycle on a clash
   assign take_b = tbi_mode && ((tog_b_reg[2] ^ tog_b_reg[1]) || pend_b_reg);

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_rx_data  <= 10'h000;
         o_rx_valid <= 1'b0;
         o_rx_port  <= 2'h0;
         pend_b_reg <= 1'b0;
      end else begin
         o_rx_valid <= take_a || take_b;
         o_rx_port  <= rx_port_reg;
         pend_b_reg <= take_a && take_b;
         if (take_a) begin
            o_rx_data <= word_a;
         end else if (take_b) begin
            o_rx_data <= word_b;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         rx_seen_reg <= 1'b0;
      end else if (take_a || take_b) begin
         rx_seen_reg <= 1'b1;
      end else if (wr_en && paddr == `PP_ADDR_STATUS && pwdata[`PP_ST_RXSEEN_BIT]) begin
         rx_seen_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit pins and indicators per port

   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_port
         logic [9:0] tx_next;
         logic       active;

         assign active = (mode_reg[p] != MODE_OFF);

         always_comb begin
            tx_next = i_tx_data[p];
            if (mode_reg[p] == MODE_FAST) begin
               tx_next = {i_tx_data[p][9:8], 4'h0, i_tx_data[p][3:0]};
            end else if (!active) begin
               tx_next = 10'h000;
            end
         end

         // transmit never gated by received traffic
         always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
               o_txd[p]                   <= 10'h000;
               o_txd_oe[p]                <= 1'b0;
               o_gig_transmit_clock[p]    <= 1'b0;
               o_gig_transmit_clock_oe[p] <= 1'b0;
               o_indicator_oe[p]          <= 1'b0;
            end else begin
               o_txd[p]                   <= tx_next;
               o_txd_oe[p]                <= active;
               o_gig_transmit_clock[p]    <= is_gig(mode_reg[p]) && !o_gig_transmit_clock[p];
               o_gig_transmit_clock_oe[p] <= is_gig(mode_reg[p]);
               o_indicator_oe[p]          <= 1'b1;
            end
         end

         always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
               o_port_link_indicator_n[p]    <= 1'b1;
               o_port_traffic_indicator_n[p] <= 1'b1;
               o_port_speed_indicator_n[p]   <= 1'b1;
            end else begin
               o_port_link_indicator_n[p]    <= !(active && (mode_reg[p] != MODE_TBI ||
                                                  (rx_port_reg == p && sync_reg[1])));
               o_port_traffic_indicator_n[p] <= !(active && (i_tx_data[p][`PP_CODE_VALID_BIT] ||
                                                  (rx_port_reg == p && (take_a || take_b))));
               o_port_speed_indicator_n[p]   <= !is_gig(mode_reg[p]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   sequence s_bad_mode_write;
      wr_en && paddr == `PP_ADDR_PORT_MODE && !wr_mode_ok;
   endsequence

   sequence s_mode_kept;
      $stable(mode_reg) && reject_reg;
   endsequence

   a_mode_refused: assert property (s_bad_mode_write |=> s_mode_kept)
      else $error("Illegal mode write was not refused");

   a_combo_legal: assert property (combo_ok(mode_reg))
      else $error("Port modes form an illegal combination");

   a_gig_pair_same: assert property (is_gig(mode_reg[1]) |-> mode_reg[1] == mode_reg[0])
      else $error("Gigabit standby port differs from port 0");

   a_rx_one_gig: assert property (is_gig(mode_reg[0]) |-> rx_port_reg[1] == 1'b0)
      else $error("Gigabit receive on a non-gigabit port");

   a_rx_port_on: assert property (mode_reg != {MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF}
                                  |-> mode_reg[rx_port_reg] != MODE_OFF || $changed(mode_reg))
      else $error("Receive port is not configured");

   a_aneg_tbi_off: assert property ($changed(mode_reg) |-> !aneg_reg)
      else $error("Auto-negotiation left on after mode change");

   a_reset_hiz: assert property (@(posedge i_clock) disable iff (1'b0)
                                 $past(!i_rstn) |-> o_txd_oe == 4'h0 && o_indicator_oe == 4'h0)
      else $error("Outputs driven during reset");

   a_speed_led: assert property (is_gig(mode_reg[0]) |=> !o_port_speed_indicator_n[0]
                                 || $changed(mode_reg))
      else $error("Speed indicator not lit in gigabit mode");

   a_mii_nibble: assert property (mode_reg[2] == MODE_FAST && $stable(mode_reg)
                                  |=> o_txd[2][7:4] == 4'h0)
      else $error("Upper nibble driven in fast mode");

   a_tx_follows: assert property (mode_reg[0] == MODE_GMII ##1 mode_reg[0] == MODE_GMII
                                  |-> o_txd[0] == $past(i_tx_data[0]))
      else $error("Transmit data stalled or altered");

   a_rx_b_tbi: assert property (o_rx_valid && !$past(tbi_mode) |-> $past(take_a))
      else $error("Second byte clock used outside TBI");

   a_apb_answer: assert property (rd_setup |=> pready ##1 !pready)
      else $error("APB answer not one cycle after setup");

endmodule

// ### hdl/rx_code_lane.sv
// Receive lane on a link clock: pin capture, frame qualify, comma sync
`include "packet_port_defines.svh"

module rx_code_lane (
   input  wire logic                  i_link_clock,
   input  wire logic                  i_rstn,
   input  wire logic [3:0][9:0]       i_rx_code,
   input  wire logic [1:0]            i_rx_port,
   input  wire logic                  i_tbi_mode,
   output logic      [9:0]            o_word,
   output logic                       o_toggle,
   output logic                       o_sync
);
   import packet_port_pkg::*;

   logic [1:0]     rst_sync_reg;
   logic [3:0]     cfg_meta_reg;
   logic [3:0]     cfg_reg;
   logic [9:0]     code_reg;
   logic [1:0]     comma_cnt_reg;
   sync_state_type sync_state_reg;
   logic           comma;

   // Reset and quasi-static config enter this domain through two flops
   always_ff @(posedge i_link_clock) begin
      rst_sync_reg <= {rst_sync_reg[0], i_rstn};
      cfg_meta_reg <= {i_tbi_mode, 1'b0, i_rx_port};
      cfg_reg      <= cfg_meta_reg;
   end

   always_ff @(posedge i_link_clock) begin
      code_reg <= i_rx_code[cfg_reg[1:0]];
   end

   always_ff @(posedge i_link_clock) begin
      if (!rst_sync_reg[1]) begin
         o_word   <= 10'h000;
         o_toggle <= 1'b0;
      end else if (cfg_reg[3] || code_reg[`PP_CODE_VALID_BIT]) begin
         o_word   <= code_reg;
         o_toggle <= ~o_toggle;
      end
   end

   assign comma = (code_reg[9:3] == `PP_COMMA_POS) || (code_reg[9:3] == `PP_COMMA_NEG);

   // code-group sync of the coding sublayer
   always_ff @(posedge i_link_clock) begin
      if (!rst_sync_reg[1] || !cfg_reg[3]) begin
         sync_state_reg <= SYNC_LOST;
         comma_cnt_reg  <= 2'h0;
      end else begin
         case (sync_state_reg)
            SYNC_LOST: begin
               comma_cnt_reg <= 2'h0;
               if (comma) begin
                  sync_state_reg <= SYNC_ACQUIRE;
                  comma_cnt_reg  <= 2'h1;
               end
            end
            SYNC_ACQUIRE: begin
               if (comma) begin
                  comma_cnt_reg <= comma_cnt_reg + 2'h1;
                  if (comma_cnt_reg == `PP_SYNC_COMMAS - 2'h1) begin
                     sync_state_reg <= SYNC_LOCKED;
                  end
               end
            end
            SYNC_LOCKED: begin
               sync_state_reg <= SYNC_LOCKED;
            end
            default: begin
               sync_state_reg <= SYNC_LOST;
            end
         endcase
      end
   end

   always_ff @(posedge i_link_clock) begin
      o_sync <= (sync_state_reg == SYNC_LOCKED);
   end

endmodule
